// [common/lcu_pkg.sv]
// Purpose: constants for the link control upper field bank
// Assumes: 32-bit register port, byte addresses
// Notes:   shared by the bank and its cycle timer
package lcu_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFF_LINK_CONTROL = 8'h08;
  localparam logic [7:0] OFF_CYCLE_TIMER  = 8'h14;
  localparam logic [7:0] OFF_ISO_PORT     = 8'h18;
  localparam logic [7:0] OFF_FIFO_CONTROL = 8'h1c;
  localparam logic [7:0] OFF_RX_STATUS    = 8'h40;

  // link_control bit positions
  localparam int unsigned BIT_TX_RESET    = 10;
  localparam int unsigned BIT_RX_RESET    = 11;
  localparam int unsigned BIT_LONG_REQ    = 15;
  localparam int unsigned BIT_CYC_MASTER  = 20;
  localparam int unsigned BIT_CYC_EXT     = 21;
  localparam int unsigned BIT_CYC_RUN     = 22;
  localparam int unsigned BIT_PARTITION   = 23;
  localparam int unsigned BIT_ISO_A       = 24;
  localparam int unsigned BIT_ISO_B       = 25;
  localparam int unsigned BIT_ACK_FLUSH   = 30;
  localparam int unsigned BIT_BAD_DISCARD = 31;

  // iso port register fields
  localparam int unsigned CHAN_W     = 6;
  localparam int unsigned ISO_A_LSB  = 8;
  localparam int unsigned ISO_B_LSB  = 0;

  // fifo control trigger size field, in quadlets
  localparam int unsigned TRIG_W     = 8;
  localparam int unsigned TRIG_LSB   = 0;

  // rx status: sticky receive_data_flag, write 1 to clear
  localparam int unsigned BIT_RX_DATA = 6;

  // cycle timer layout
  localparam int unsigned SUB_W       = 12;
  localparam int unsigned TICK_W      = 13;
  localparam int unsigned SUB_LSB     = 0;
  localparam int unsigned TICK_LSB    = 12;
  localparam logic [11:0] SUB_MAX     = 12'hbff;
  localparam logic [12:0] TICK_MAX    = 13'h1f3f;

  // reset values
  localparam logic [31:0] RST_LINK_CONTROL = 32'h0000_0000;
  localparam logic [31:0] RST_ISO_PORT     = 32'h0000_0000;
  localparam logic [31:0] RST_FIFO_CONTROL = 32'h0000_0000;
  localparam logic [31:0] RST_ZERO         = 32'h0000_0000;
  localparam logic [7:0]  RST_QUAD_COUNT   = 8'h00;
  localparam logic [11:0] RST_SUB          = 12'h000;
  localparam logic [12:0] RST_TICK         = 13'h0000;
endpackage : lcu_pkg

// [tb/lcu_link_control_assertions.sv]
// Purpose: port-level checks of the link control upper bank
// Assumes: single clock, synchronous active-low reset
// Notes:   bound into lcu_link_control by name
`timescale 1ns/1ps
`default_nettype none
module lcu_link_control_chk (
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic [lcu_pkg::ADDR_W-1:0] regAddr,
  input wire logic [lcu_pkg::DATA_W-1:0] regWrData,
  input wire logic                       regWrite,
  input wire logic                       regRead,
  input wire logic [lcu_pkg::DATA_W-1:0] regRdData,
  input wire logic                       phyIsRoot,
  input wire logic                       busReset,
  input wire logic                       rxEnd,
  input wire logic                       rxSoftReset,
  input wire logic                       txSoftReset,
  input wire logic                       ackQueueFlush,
  input wire logic                       longBusRequestSelect,
  input wire logic                       cycleMasterActive,
  input wire logic                       cycleStartSend,
  input wire logic                       rxBlockCommit,
  input wire logic                       rxPacketDrop,
  input wire logic                       receiveDataFlag
);
  // reserved bits 12-14, 16-19 and 26-29 plus self-clearing bits 10, 11 and 30; reserved bits 0-9 not checked
  localparam logic [31:0] ZMSK = 32'h7c0f7c00;
  wire logic wCtl = regWrite && regAddr == lcu_pkg::OFF_LINK_CONTROL;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rx_reset: assert property (wCtl && regWrData[11] |=> rxSoftReset)
    else $error("receiver reset pulse missing");
  a_rx_cause: assert property (rxSoftReset |->
    $past(wCtl && regWrData[11]))
    else $error("receiver reset without write");
  a_tx_reset: assert property (wCtl && regWrData[10] |=>
    txSoftReset && ackQueueFlush)
    else $error("transmitter reset or flush missing");
  a_flush_cause: assert property (ackQueueFlush |->
    $past(wCtl && (regWrData[30] || regWrData[10])))
    else $error("flush without cause");
  a_ack_flush: assert property (wCtl && regWrData[30] |=> ackQueueFlush)
    else $error("flush pulse missing");
  a_long_req: assert property (wCtl |=>
    longBusRequestSelect == $past(regWrData[15]))
    else $error("long request select wrong");
  a_master_root: assert property (cycleMasterActive |->
    $past(phyIsRoot))
    else $error("master active without root");
  a_start_master: assert property (cycleStartSend |->
    cycleMasterActive || $past(cycleMasterActive))
    else $error("cycle start while not master");
  a_bus_reset_keep: assert property (busReset && cycleMasterActive && phyIsRoot
    && !regWrite |=> cycleMasterActive)
    else $error("bus reset dropped master");
  a_reserved_zero: assert property (regRead &&
    regAddr == lcu_pkg::OFF_LINK_CONTROL |=> (regRdData & ZMSK) == 32'h0)
    else $error("reserved bits read nonzero");
  a_drop_excl: assert property (rxPacketDrop |->
    !rxBlockCommit && $past(rxEnd))
    else $error("drop timing or commit clash");
  a_commit_flag: assert property (rxBlockCommit |-> receiveDataFlag)
    else $error("commit without data flag");
  c_commit: cover property (rxBlockCommit);
  c_start: cover property (cycleStartSend);
  c_drop: cover property (rxPacketDrop);
endmodule : lcu_link_control_chk
bind lcu_link_control lcu_link_control_chk chk_i (.clk, .rst_n, .regAddr,
  .regWrData, .regWrite, .regRead, .regRdData, .phyIsRoot, .busReset, .rxEnd,
  .rxSoftReset, .txSoftReset, .ackQueueFlush, .longBusRequestSelect,
  .cycleMasterActive, .cycleStartSend, .rxBlockCommit, .rxPacketDrop,
  .receiveDataFlag);
`default_nettype wire

// [tb/lcu_phy_model.sv]
// Purpose: phy side stand-in: root status, bus reset, sync pin
// Assumes: requests come from the bench on the clock
// Notes:   sync pin rises off the clock grid, idles low
`timescale 1ns/1ps
`default_nettype none
module lcu_phy_model (
  input  wire logic clk,
  input  wire logic rootReq,
  input  wire logic bresReq,
  input  wire logic syncReq,
  output var  logic phyIsRoot,
  output var  logic busReset,
  output var  logic cycleSyncIn
);
  logic [2:0] hiCnt = 3'h0;
  initial begin
    phyIsRoot = 1'b0;
    busReset = 1'b0;
    cycleSyncIn = 1'b0;
  end
  always @(posedge clk) begin
    phyIsRoot <= rootReq;
    busReset <= bresReq;
    if (syncReq) hiCnt <= 3'h5;
    else if (hiCnt != 3'h0) hiCnt <= hiCnt - 3'h1;
  end
  // pin skewed from the clock, several cycles wide
  always @(hiCnt) cycleSyncIn <= #37 (hiCnt != 3'h0);
endmodule : lcu_phy_model
`default_nettype wire

// [tb/tb_lcu_link_control.sv]
// Purpose: self-checking bench for the link control upper bank
// Assumes: reads checked from queue, output pulses from event queue
// Notes:   an unexpected output pulse counts as a mismatch
`timescale 1ns/1ps
`default_nettype none
module tb_lcu_link_control;
  localparam logic [31:0] RES = 32'h3c0f7000;
  localparam logic [31:0] TMSK = 32'h01fff000;
  localparam logic [6:0] E_TX = 7'h18, E_FL = 7'h08, E_CS = 7'h04;
  localparam logic [6:0] E_RX = 7'h20, E_CM = 7'h02, E_DR = 7'h01;
  localparam logic [6:0] E_IA = 7'h40;
  logic clk, rst_n, regWrite, regRead, rxStart, rxIso, rxQuad, rxEnd;
  logic rxBad, rxQueueFull, rootReq, bresReq, syncReq, phyIsRoot;
  logic busReset, cycleSyncIn, rxSoftReset, txSoftReset, ackQueueFlush;
  logic longBusRequestSelect, cycleMasterActive, cycleStartSend;
  logic rxBlockCommit, rxPacketDrop, rxIsoAccept, receiveDataFlag;
  logic [7:0]  regAddr;
  logic [31:0] regWrData, regRdData, ctl;
  logic [5:0]  rxChannel;
  logic        rdSeen = 1'b0;
  logic [31:0] qd[$], qm[$];
  logic [6:0]  qe[$];
  int n_fail = 0, compares = 0, cyc = 0;
  wire logic [6:0] obs = {rxIsoAccept, rxSoftReset, txSoftReset,
    ackQueueFlush, cycleStartSend, rxBlockCommit, rxPacketDrop};
  lcu_link_control lcu_link_control_i (.clk, .rst_n, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .phyIsRoot, .busReset, .cycleSyncIn,
    .rxStart, .rxIso, .rxChannel, .rxQuad, .rxEnd, .rxBad, .rxQueueFull,
    .rxSoftReset, .txSoftReset, .ackQueueFlush, .longBusRequestSelect,
    .cycleMasterActive, .cycleStartSend, .rxBlockCommit, .rxPacketDrop,
    .rxIsoAccept, .receiveDataFlag);
  lcu_phy_model lcu_phy_model_i (.clk, .rootReq, .bresReq, .syncReq,
    .phyIsRoot, .busReset, .cycleSyncIn);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic idle(input int n);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    syncReq <= 1'b0;
    bresReq <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    regRead <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = '1);
    qd.push_back(e);
    qm.push_back(m);
    regAddr <= a;
    regRead <= 1'b1;
    regWrite <= 1'b0;
    @(posedge clk);
  endtask : rd
  // one-cycle request to the phy stand-in: sync edge or bus reset
  task automatic phyReq(input logic isSync, input int n);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    if (isSync) syncReq <= 1'b1;
    else bresReq <= 1'b1;
    @(posedge clk);
    idle(n);
  endtask : phyReq
  task automatic pkt(input logic iso, input logic [5:0] ch, input int n,
                     input logic bad, input logic full);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    rxStart <= 1'b1;
    rxIso <= iso;
    rxChannel <= ch;
    @(posedge clk);
    rxStart <= 1'b0;
    for (int i = 1; i <= n; i++) begin
      rxQuad <= 1'b1;
      rxEnd <= (i == n);
      rxBad <= bad && (i == n);
      rxQueueFull <= full && (i == n);
      @(posedge clk);
    end
    {rxQuad, rxEnd, rxBad, rxQueueFull} <= 4'h0;
    idle(4);
  endtask : pkt
  task automatic chkRd(input logic [31:0] g, e, m);
    compares++;
    if ((g & m) !== (e & m)) begin
      n_fail++;
      $display("BAD %0t read %h exp %h", $time, g, e);
    end
  endtask : chkRd
  task automatic chkEv(input logic [6:0] g);
    logic [6:0] e;
    e = (qe.size() != 0) ? qe.pop_front() : 7'h00;
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t event %h exp %h", $time, g, e);
    end
  endtask : chkEv
  task automatic tally_and_finish;
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    rdSeen <= regRead && rst_n;
    if (rdSeen) chkRd(regRdData, qd.pop_front(), qm.pop_front());
    if (rst_n && obs !== 7'h00) chkEv(obs);
  end
  initial begin
    {regWrite, regRead, rxStart, rxIso, rxQuad, rxEnd} = 6'h0;
    {rxBad, rxQueueFull, rootReq, bresReq, syncReq, rst_n} = 6'h0;
    regAddr = 8'h00;
    regWrData = 32'h0;
    rxChannel = 6'h00;
    ctl = 32'h0;
    void'($urandom(32'h1f11a27f));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(lcu_pkg::OFF_LINK_CONTROL, 32'h0);
    rd(lcu_pkg::OFF_CYCLE_TIMER, 32'h0);
    rd(8'hf0, 32'h0);
    wr(lcu_pkg::OFF_LINK_CONTROL, $urandom & RES);
    rd(lcu_pkg::OFF_LINK_CONTROL, 32'h0);
    ctl = 32'h0000_8000;
    wr(lcu_pkg::OFF_LINK_CONTROL, ctl);
    qe.push_back(E_RX);
    wr(lcu_pkg::OFF_LINK_CONTROL, ctl | 32'h0000_0800);
    qe.push_back(E_FL);
    wr(lcu_pkg::OFF_LINK_CONTROL, ctl | 32'h4000_0000);
    qe.push_back(E_TX);
    wr(lcu_pkg::OFF_LINK_CONTROL, ctl | 32'h0000_0400);
    rd(lcu_pkg::OFF_LINK_CONTROL, ctl);
    wr(lcu_pkg::OFF_LINK_CONTROL, 32'h0040_0000);
    phyReq(1'b1, 8);
    rd(lcu_pkg::OFF_CYCLE_TIMER, 32'h0, TMSK);
    rootReq <= 1'b1;
    ctl = 32'h0030_0000;
    wr(lcu_pkg::OFF_LINK_CONTROL, ctl);
    idle(3);
    phyReq(1'b1, 10);
    ctl = 32'h0070_0000;
    wr(lcu_pkg::OFF_LINK_CONTROL, ctl);
    idle(3);
    qe.push_back(E_CS);
    phyReq(1'b1, 10);
    rd(lcu_pkg::OFF_CYCLE_TIMER, 32'h0000_2000, TMSK);
    phyReq(1'b0, 3);
    rd(lcu_pkg::OFF_LINK_CONTROL, ctl);
    rootReq <= 1'b0;
    idle(3);
    phyReq(1'b1, 10);
    ctl = 32'h0;
    wr(lcu_pkg::OFF_LINK_CONTROL, ctl);
    wr(lcu_pkg::OFF_FIFO_CONTROL, 32'h2);
    wr(lcu_pkg::OFF_LINK_CONTROL, 32'h0080_0000);
    repeat (2) qe.push_back(E_CM);
    pkt(1'b0, 6'h00, 3, 1'b0, 1'b0);
    rd(lcu_pkg::OFF_RX_STATUS, 32'h40);
    wr(lcu_pkg::OFF_LINK_CONTROL, 32'h8080_0000);
    qe.push_back(E_CM);
    pkt(1'b0, 6'h00, 3, 1'b0, 1'b0);
    wr(lcu_pkg::OFF_RX_STATUS, 32'h40);
    repeat (2) qe.push_back(E_DR);
    pkt(1'b0, 6'h00, 2, 1'b1, 1'b0);
    pkt(1'b0, 6'h00, 2, 1'b0, 1'b1);
    rd(lcu_pkg::OFF_RX_STATUS, 32'h0);
    wr(lcu_pkg::OFF_ISO_PORT, 32'h0509);
    wr(lcu_pkg::OFF_LINK_CONTROL, 32'h0100_0000);
    pkt(1'b1, 6'h09, 1, 1'b0, 1'b0);
    qe.push_back(E_IA);
    qe.push_back(E_CM);
    pkt(1'b1, 6'h05, 1, 1'b0, 1'b0);
    wr(lcu_pkg::OFF_LINK_CONTROL, 32'h0200_0000);
    qe.push_back(E_IA);
    qe.push_back(E_CM);
    pkt(1'b1, 6'h09, 1, 1'b0, 1'b0);
    pkt(1'b1, 6'(10 + $urandom % 40), 1, 1'b0, 1'b0);
    idle(5);
    if (qe.size() != 0) begin
      n_fail++;
      $display("BAD %0t missing output events", $time);
    end
    tally_and_finish();
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      $display("BAD %0t timeout", $time);
      tally_and_finish();
    end
  end
endmodule : tb_lcu_link_control
`default_nettype wire

// [verilog/lcu_cycle_timer.sv]
// Purpose: cycle timer counters feeding cycle start generation
// Assumes: syncEdge is a one-cycle pulse already filtered
// Notes:   sub tick wraps at subMax, tick count at tickMax
`timescale 1ns/1ps
`default_nettype none
module lcu_cycle_timer #(
  parameter int unsigned SUB_W  = lcu_pkg::SUB_W,
  parameter int unsigned TICK_W = lcu_pkg::TICK_W,
  parameter logic [SUB_W-1:0]  SUB_MAX  = lcu_pkg::SUB_MAX,
  parameter logic [TICK_W-1:0] TICK_MAX = lcu_pkg::TICK_MAX
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              run,
  input  wire logic              extSource,
  input  wire logic              syncEdge,
  output var  logic [SUB_W-1:0]  subTick,
  output var  logic [TICK_W-1:0] tickCount,
  output var  logic              tickInc
);
  logic subWrap;
  logic doTick;

  assign subWrap = run && (subTick == SUB_MAX);
  assign doTick  = extSource ? syncEdge : subWrap; // [R7] [R8]

  // sub cycle tick
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      subTick <= lcu_pkg::RST_SUB;
    end else if (extSource && syncEdge) begin
      subTick <= lcu_pkg::RST_SUB; // [R7]
    end else if (run) begin
      subTick <= subWrap ? lcu_pkg::RST_SUB : subTick + 1'b1; // [R9]
    end
  end

  // cycle tick counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tickCount <= lcu_pkg::RST_TICK;
      tickInc   <= 1'b0;
    end else begin
      tickInc <= doTick;
      if (doTick) begin
        tickCount <= (tickCount == TICK_MAX) ? lcu_pkg::RST_TICK
                                             : tickCount + 1'b1;
      end
    end
  end
endmodule : lcu_cycle_timer
`default_nettype wire

// [verilog/lcu_link_control.sv]
// Purpose: upper link control fields and their receive/cycle effects
// Assumes: single clock, rx strobes come from same-clock receiver logic
// Notes:   registers at byte offsets, read data one cycle after strobe
//
// How it works
// R1: bit 11 pulses receiver reset, self-clears
// R2: bit 15 selects long bus request form
// R3: cycle master needs enable and root PHY
// R4: cycle start sent on each tick increment; code sends none when it meets a txSoftReset pulse
// R5: bus reset keeps cycle master enable
// R6: software clears master enable when not root
// R7: external mode: sync edge counts, zeroes sub
// R8: internal mode: count on sub rollover only
// R9: sub tick advances only while run set
// R10: no cycle start without timer run
// R11: partition enable splits packets by trigger size
// R12: completed blocks commit before packet ends
// R13: port a enable accepts matching channel
// R14: port b enable accepts matching channel
// R15: bit 30 flushes ack queue, self-clears
// R16: transmitter reset also flushes ack queue
// R17: discard bad packets, no data flag
// R18: discard forces partitioning off
// R19: bit 10 pulses transmitter reset, self-clears
// R20: data flag set per committed block
// R21: reserved bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
module lcu_link_control #(
  parameter int unsigned CHAN_W = lcu_pkg::CHAN_W,
  parameter int unsigned TRIG_W = lcu_pkg::TRIG_W
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [lcu_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [lcu_pkg::DATA_W-1:0] regWrData,
  input  wire logic                      regWrite,
  input  wire logic                      regRead,
  output var  logic [lcu_pkg::DATA_W-1:0] regRdData,
  input  wire logic                      phyIsRoot,
  input  wire logic                      busReset,
  input  wire logic                      cycleSyncIn,
  input  wire logic                      rxStart,
  input  wire logic                      rxIso,
  input  wire logic [CHAN_W-1:0]         rxChannel,
  input  wire logic                      rxQuad,
  input  wire logic                      rxEnd,
  input  wire logic                      rxBad,
  input  wire logic                      rxQueueFull,
  output var  logic                      rxSoftReset,
  output var  logic                      txSoftReset,
  output var  logic                      ackQueueFlush,
  output var  logic                      longBusRequestSelect,
  output var  logic                      cycleMasterActive,
  output var  logic                      cycleStartSend,
  output var  logic                      rxBlockCommit,
  output var  logic                      rxPacketDrop,
  output var  logic                      rxIsoAccept,
  output var  logic                      receiveDataFlag
);
  typedef enum logic [1:0] {
    LCU_RX_IDLE,
    LCU_RX_TAKE,
    LCU_RX_SKIP
  } lcu_rx_e;

  // stored control fields
  logic                  cycMasterEn_reg;
  logic                  cycExt_reg;
  logic                  cycRun_reg;
  logic                  partEn_reg;
  logic                  isoAEn_reg;
  logic                  isoBEn_reg;
  logic                  badDiscard_reg;
  logic [CHAN_W-1:0]     isoChanA_reg;
  logic [CHAN_W-1:0]     isoChanB_reg;
  logic [TRIG_W-1:0]     trigSize_reg;

  // receive path state
  lcu_rx_e               rxState_reg;
  lcu_rx_e               rxState_next;
  logic [TRIG_W-1:0]     quadCount_reg;
  logic                  pktBad_reg;
  logic                  rxDataFlag_reg;

  // sync and timer
  logic                  sync1_reg;
  logic                  sync2_reg;
  logic                  sync3_reg;
  logic                  syncLevel_reg;
  logic                  syncEdge;
  logic [lcu_pkg::SUB_W-1:0]  subTick;
  logic [lcu_pkg::TICK_W-1:0] tickCount;
  logic                  tickInc;

  // decode and helpers
  logic                  wrCtrl;
  logic                  wrIso;
  logic                  wrFifo;
  logic                  wrStat;
  logic                  partActive;
  logic                  chanMatch;
  logic                  blockFull;
  logic                  badNow;
  logic                  commitBlock;
  logic                  endGood;
  logic                  endDrop;
  logic [lcu_pkg::DATA_W-1:0] ctrlView;
  logic [lcu_pkg::DATA_W-1:0] rdValue;

  assign wrCtrl = regWrite && (regAddr == lcu_pkg::OFF_LINK_CONTROL);
  assign wrIso  = regWrite && (regAddr == lcu_pkg::OFF_ISO_PORT);
  assign wrFifo = regWrite && (regAddr == lcu_pkg::OFF_FIFO_CONTROL);
  assign wrStat = regWrite && (regAddr == lcu_pkg::OFF_RX_STATUS);

  // control register fields, reserved bits not stored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cycMasterEn_reg      <= 1'b0;
      cycExt_reg           <= 1'b0;
      cycRun_reg           <= 1'b0;
      partEn_reg           <= 1'b0;
      isoAEn_reg           <= 1'b0;
      isoBEn_reg           <= 1'b0;
      badDiscard_reg       <= 1'b0;
      longBusRequestSelect <= 1'b0;
    end else if (wrCtrl) begin // [R21]
      // busReset deliberately absent here [R5]
      cycMasterEn_reg      <= regWrData[lcu_pkg::BIT_CYC_MASTER]; // [R6]
      cycExt_reg           <= regWrData[lcu_pkg::BIT_CYC_EXT];
      cycRun_reg           <= regWrData[lcu_pkg::BIT_CYC_RUN];
      partEn_reg           <= regWrData[lcu_pkg::BIT_PARTITION];
      isoAEn_reg           <= regWrData[lcu_pkg::BIT_ISO_A];
      isoBEn_reg           <= regWrData[lcu_pkg::BIT_ISO_B];
      badDiscard_reg       <= regWrData[lcu_pkg::BIT_BAD_DISCARD];
      longBusRequestSelect <= regWrData[lcu_pkg::BIT_LONG_REQ]; // [R2]
    end
  end

  // self-clearing reset and flush pulses
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxSoftReset   <= 1'b0;
      txSoftReset   <= 1'b0;
      ackQueueFlush <= 1'b0;
    end else begin
      rxSoftReset   <= wrCtrl && regWrData[lcu_pkg::BIT_RX_RESET]; // [R1]
      txSoftReset   <= wrCtrl && regWrData[lcu_pkg::BIT_TX_RESET]; // [R19]
      ackQueueFlush <= wrCtrl && (regWrData[lcu_pkg::BIT_ACK_FLUSH]
                       || regWrData[lcu_pkg::BIT_TX_RESET]); // [R15] [R16]
    end
  end

  // iso channel and trigger size fields
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      isoChanA_reg <= lcu_pkg::RST_ISO_PORT[lcu_pkg::ISO_A_LSB +: CHAN_W];
      isoChanB_reg <= lcu_pkg::RST_ISO_PORT[lcu_pkg::ISO_B_LSB +: CHAN_W];
      trigSize_reg <= lcu_pkg::RST_FIFO_CONTROL[lcu_pkg::TRIG_LSB +: TRIG_W];
    end else begin
      if (wrIso) begin
        isoChanA_reg <= regWrData[lcu_pkg::ISO_A_LSB +: CHAN_W];
        isoChanB_reg <= regWrData[lcu_pkg::ISO_B_LSB +: CHAN_W];
      end
      if (wrFifo) begin
        trigSize_reg <= regWrData[lcu_pkg::TRIG_LSB +: TRIG_W];
      end
    end
  end

  // cycle sync pin: three flops, change once second and third agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg     <= 1'b0;
      sync2_reg     <= 1'b0;
      sync3_reg     <= 1'b0;
      syncLevel_reg <= 1'b0;
    end else begin
      sync1_reg <= cycleSyncIn;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg) begin
        syncLevel_reg <= sync3_reg;
      end
    end
  end

  assign syncEdge = (sync2_reg == sync3_reg) && sync3_reg && !syncLevel_reg;

  lcu_cycle_timer #(
    .SUB_W    (lcu_pkg::SUB_W),
    .TICK_W   (lcu_pkg::TICK_W),
    .SUB_MAX  (lcu_pkg::SUB_MAX),
    .TICK_MAX (lcu_pkg::TICK_MAX)
  ) u_timer (
    .clk       (clk),
    .rst_n     (rst_n),
    .run       (cycRun_reg),
    .extSource (cycExt_reg),
    .syncEdge  (syncEdge),
    .subTick   (subTick),
    .tickCount (tickCount),
    .tickInc   (tickInc)
  );

  // cycle master and cycle start requests
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cycleMasterActive <= 1'b0;
      cycleStartSend    <= 1'b0;
    end else begin
      cycleMasterActive <= cycMasterEn_reg && phyIsRoot; // [R3]
      cycleStartSend    <= tickInc && cycleMasterActive
                           && cycRun_reg && !txSoftReset; // [R4] [R10]
    end
  end

  // receive filtering and partitioning
  assign partActive = partEn_reg && !badDiscard_reg
                      && (trigSize_reg != '0); // [R11] [R18]
  assign chanMatch  = (isoAEn_reg && (rxChannel == isoChanA_reg))   // [R13]
                      || (isoBEn_reg && (rxChannel == isoChanB_reg)); // [R14]
  assign badNow     = pktBad_reg || rxBad || rxQueueFull;
  assign blockFull  = rxQuad && partActive
                      && (quadCount_reg == trigSize_reg - 1'b1);
  assign endDrop    = rxEnd && badNow && badDiscard_reg; // [R17]
  assign endGood    = rxEnd && !endDrop;
  assign commitBlock = (rxState_reg == LCU_RX_TAKE)
                       && ((blockFull && !rxEnd) || endGood); // [R12]

  always_comb begin
    rxState_next = rxState_reg;
    case (rxState_reg)
      LCU_RX_IDLE: begin
        if (rxStart) begin
          rxState_next = (!rxIso || chanMatch) ? LCU_RX_TAKE : LCU_RX_SKIP;
        end
      end
      LCU_RX_TAKE: begin
        if (rxEnd) begin
          rxState_next = LCU_RX_IDLE;
        end
      end
      LCU_RX_SKIP: begin
        if (rxEnd) begin
          rxState_next = LCU_RX_IDLE;
        end
      end
      default: begin
        rxState_next = LCU_RX_IDLE;
      end
    endcase
  end

  // receiver state, cleared by receiver soft reset
  always_ff @(posedge clk) begin
    if (!rst_n || rxSoftReset) begin // [R1]
      rxState_reg   <= LCU_RX_IDLE;
      quadCount_reg <= lcu_pkg::RST_QUAD_COUNT[TRIG_W-1:0];
      pktBad_reg    <= 1'b0;
    end else begin
      rxState_reg <= rxState_next;
      if (rxStart || rxEnd || blockFull) begin
        quadCount_reg <= lcu_pkg::RST_QUAD_COUNT[TRIG_W-1:0];
      end else if (rxQuad && (rxState_reg == LCU_RX_TAKE)) begin
        quadCount_reg <= quadCount_reg + 1'b1;
      end
      if (rxStart || rxEnd) begin
        pktBad_reg <= 1'b0;
      end else if (rxBad || rxQueueFull) begin
        pktBad_reg <= 1'b1;
      end
    end
  end

  // receive outputs
  always_ff @(posedge clk) begin
    if (!rst_n || rxSoftReset) begin
      rxBlockCommit <= 1'b0;
      rxPacketDrop  <= 1'b0;
      rxIsoAccept   <= 1'b0;
    end else begin
      rxBlockCommit <= commitBlock;
      rxPacketDrop  <= (rxState_reg == LCU_RX_TAKE) && endDrop; // [R17]
      if (rxStart) begin
        rxIsoAccept <= rxIso && chanMatch;
      end else if (rxEnd) begin
        rxIsoAccept <= 1'b0;
      end
    end
  end

  // sticky data flag, set wins over clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxDataFlag_reg  <= 1'b0;
      receiveDataFlag <= 1'b0;
    end else begin
      if (commitBlock) begin
        rxDataFlag_reg <= 1'b1; // [R20]
      end else if (wrStat && regWrData[lcu_pkg::BIT_RX_DATA]) begin
        rxDataFlag_reg <= 1'b0;
      end
      receiveDataFlag <= commitBlock || rxDataFlag_reg;
    end
  end

  // read view of control register, reserved and pulse bits zero
  always_comb begin
    ctrlView = lcu_pkg::RST_ZERO; // [R21]
    ctrlView[lcu_pkg::BIT_LONG_REQ]    = longBusRequestSelect;
    ctrlView[lcu_pkg::BIT_CYC_MASTER]  = cycMasterEn_reg;
    ctrlView[lcu_pkg::BIT_CYC_EXT]     = cycExt_reg;
    ctrlView[lcu_pkg::BIT_CYC_RUN]     = cycRun_reg;
    ctrlView[lcu_pkg::BIT_PARTITION]   = partEn_reg;
    ctrlView[lcu_pkg::BIT_ISO_A]       = isoAEn_reg;
    ctrlView[lcu_pkg::BIT_ISO_B]       = isoBEn_reg;
    ctrlView[lcu_pkg::BIT_BAD_DISCARD] = badDiscard_reg;
  end

  always_comb begin
    rdValue = lcu_pkg::RST_ZERO;
    case (regAddr)
      lcu_pkg::OFF_LINK_CONTROL: begin
        rdValue = ctrlView;
      end
      lcu_pkg::OFF_CYCLE_TIMER: begin
        rdValue[lcu_pkg::SUB_LSB +: lcu_pkg::SUB_W]   = subTick;
        rdValue[lcu_pkg::TICK_LSB +: lcu_pkg::TICK_W] = tickCount;
      end
      lcu_pkg::OFF_ISO_PORT: begin
        rdValue[lcu_pkg::ISO_A_LSB +: CHAN_W] = isoChanA_reg;
        rdValue[lcu_pkg::ISO_B_LSB +: CHAN_W] = isoChanB_reg;
      end
      lcu_pkg::OFF_FIFO_CONTROL: begin
        rdValue[lcu_pkg::TRIG_LSB +: TRIG_W] = trigSize_reg;
      end
      lcu_pkg::OFF_RX_STATUS: begin
        rdValue[lcu_pkg::BIT_RX_DATA] = rxDataFlag_reg;
      end
      default: begin
        rdValue = lcu_pkg::RST_ZERO;
      end
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdData <= lcu_pkg::RST_ZERO;
    end else if (regRead) begin
      regRdData <= rdValue;
    end else begin
      regRdData <= lcu_pkg::RST_ZERO;
    end
  end
endmodule : lcu_link_control
`default_nettype wire
